/* rtl/cpes_pkg.sv */
`default_nettype none
package cpes_pkg;
  // Widths and sizes
  localparam int CNT_W = 3;
  localparam int INC_W = CNT_W + 1;
  localparam int CTR_W = 48;
  localparam int NUM_PROG = 2;
  localparam int NUM_FIX = 3;
  localparam int FILT_W = 16;
  localparam int ADDR_W = 32;
  localparam int PEND_N = 8;
  localparam int FAIR_LIMIT = 4;
  // Event codes
  localparam logic [7:0] EVC_CYCLES = 8'h3c;
  localparam logic [7:0] EVC_IFETCH = 8'h80;
  localparam logic [7:0] EVC_NIP = 8'hb6;
  localparam logic [7:0] EVC_OFFCORE = 8'hb7;
  localparam logic [7:0] EVC_INST = 8'hc0;
  localparam logic [7:0] EVC_UOPS = 8'hc2;
  localparam logic [7:0] EVC_L2Q_REJ = 8'h31;
  localparam logic [7:0] EVC_XQ_REJ = 8'h30;
  // Unit masks
  localparam logic [7:0] UM_00 = 8'h00;
  localparam logic [7:0] UM_01 = 8'h01;
  localparam logic [7:0] UM_02 = 8'h02;
  localparam logic [7:0] UM_03 = 8'h03;
  localparam logic [7:0] UM_04 = 8'h04;
  localparam logic [7:0] UM_10 = 8'h10;
  // Fixed counter slots
  localparam int FIX_INST = 0;
  localparam int FIX_CORE = 1;
  localparam int FIX_REF = 2;
  typedef enum logic [3:0] {
    EV_CORE_CYC = 4'h0,
    EV_REF_CYC = 4'h1,
    EV_IC_HIT = 4'h2,
    EV_IC_MISS = 4'h3,
    EV_IC_ALL = 4'h4,
    EV_NIP_STALL = 4'h5,
    EV_OFC0 = 4'h6,
    EV_OFC1 = 4'h7,
    EV_INST = 4'h8,
    EV_UOP_MS = 4'h9,
    EV_UOP_ALL = 4'ha,
    EV_L2Q_REJ = 4'hb,
    EV_XQ_REJ = 4'hc,
    EV_NONE = 4'hd
  } cpes_evt_e;
  localparam int EV_NUM = 13;
endpackage
`default_nettype wire

/* rtl/cpes_counter.sv */
`default_nettype none
module cpes_counter
  import cpes_pkg::*;
#(
  parameter int W = CTR_W,
  parameter int IW = INC_W
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Control
  input wire logic clear,
  input wire logic [IW-1:0] incAmt,
  // Value
  output logic [W-1:0] count
);
  typedef struct packed {
    logic [W-1:0] count;
  } cpes_ctr_s;
  cpes_ctr_s state_q;
  cpes_ctr_s state_d;

  // Adds the whole per-cycle amount; wraps silently, nothing flags overflow
  always_comb
  begin
    state_d = state_q;
    if (clear)
      state_d.count = '0;
    else
      state_d.count = state_q.count + W'(incAmt);
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      state_q <= '0;
    else
      state_q <= state_d;
  end

  assign count = state_q.count;

  accum_step_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !clear |=> count == $past(count) + W'($past(incAmt)))
    else $error("counter did not add the full amount");
endmodule
`default_nettype wire

/* rtl/cpes_queue_admit.sv */
`default_nettype none
module cpes_queue_admit
  import cpes_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Core request
  input wire logic reqValid,
  input wire logic reqDirtyEvict,
  input wire logic [ADDR_W-1:0] reqAddr,
  // Queue view
  input wire logic [PEND_N-1:0] pendValid,
  input wire logic [PEND_N-1:0][ADDR_W-1:0] pendAddr,
  input wire logic queueFull,
  input wire logic queueNearFull,
  input wire logic otherWaiting,
  // Decision
  output logic reqAccept,
  output logic reqReject
);
  typedef struct packed {
    logic [2:0] streak;
  } cpes_qa_s;
  cpes_qa_s state_q;
  cpes_qa_s state_d;
  logic conflict;
  logic unfair;
  logic rejectAll;

  // Pending entries include external snoops, so all of them are compared
  always_comb
  begin
    conflict = 1'b0;
    for (int i = 0; i < PEND_N; i++)
      if (pendValid[i] && pendAddr[i] == reqAddr)
        conflict = 1'b1;
  end

  assign unfair = otherWaiting && (int'(state_q.streak) >= FAIR_LIMIT);
  assign rejectAll = queueFull || queueNearFull || unfair || (reqDirtyEvict && conflict);
  assign reqReject = reqValid && rejectAll;
  assign reqAccept = reqValid && !rejectAll;

  // Streak only grows while the other core is kept waiting
  always_comb
  begin
    state_d = state_q;
    if (!otherWaiting || reqReject)
      state_d.streak = '0;
    else if (reqAccept)
      state_d.streak = state_q.streak + 3'h1;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      state_q <= '0;
    else
      state_q <= state_d;
  end

  full_reject_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    reqValid && queueFull |-> reqReject && !reqAccept)
    else $error("request accepted into a full queue");
  evict_conflict_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    reqValid && reqDirtyEvict && conflict |-> reqReject)
    else $error("conflicting dirty eviction accepted");
  fair_share_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (reqAccept && otherWaiting) [*4] |=> !(reqAccept && otherWaiting))
    else $error("core monopolised the shared queue");
endmodule
`default_nettype wire

/* rtl/cpes_top.sv */
// Behaviour
// - Shared request queue rejects when full, or to keep fairness between cores.
// - Dirty eviction conflicting with any pending entry, snoops included, may be rejected.
// - Code 3C mask 00 counts every core cycle not halted.
// - Fixed counter 1 counts the same unhalted core cycles.
// - Code 3C mask 01 counts unhalted reference cycles at maximum frequency.
// - Fixed counter 2 counts the same unhalted reference cycles.
// - Code 80 mask 01 counts fetches served from instruction cache.
// - Code 80 mask 02 counts each miss or uncacheable fetch once.
// - Code 80 mask 03 counts every instruction fetch.
// - Mask 04 stall event counts every cycle fetch pointer stalls on miss.
// - Off-core events count only types chosen by their own filter register.
// - Instructions retired counts once when the last micro-op retires.
// - Retired instruction count continues through interrupts, traps and handlers.
// - Fixed counter 0 counts the same retired instructions.
// - Code C2 mask 01 counts retired micro-ops from microcode ROM.
// - Code C2 mask 10 counts all retired micro-ops.
// - Code 31 mask 00 counts requests rejected by shared request queue.
// - Code 30 mask 00 counts transactions rejected by external queue.
`default_nettype none
module cpes_top
  import cpes_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Counter control
  input wire logic [NUM_PROG-1:0][7:0] progEvtCode,
  input wire logic [NUM_PROG-1:0][7:0] progUmask,
  input wire logic [NUM_PROG-1:0] progEnable,
  input wire logic [NUM_FIX-1:0] fixEnable,
  input wire logic ctrClear,
  // Off-core response filters
  input wire logic [FILT_W-1:0] offcoreFilterZero,
  input wire logic [FILT_W-1:0] offcoreFilterOne,
  // Pipeline events
  input wire logic coreHalted,
  input wire logic [CNT_W-1:0] refTicks,
  input wire logic [CNT_W-1:0] retiredInstr,
  input wire logic [CNT_W-1:0] retiredUops,
  input wire logic [CNT_W-1:0] retiredMsUops,
  // Fetch events
  input wire logic [CNT_W-1:0] fetchHit,
  input wire logic [CNT_W-1:0] fetchUncache,
  input wire logic fetchMissPend,
  input wire logic nipStallMiss,
  // Off-core responses
  input wire logic offcoreValid,
  input wire logic [FILT_W-1:0] offcoreType,
  // Shared request queue
  input wire logic coreReqValid,
  input wire logic coreReqDirtyEvict,
  input wire logic [ADDR_W-1:0] coreReqAddr,
  input wire logic [PEND_N-1:0] pendValid,
  input wire logic [PEND_N-1:0][ADDR_W-1:0] pendAddr,
  input wire logic queueFull,
  input wire logic queueNearFull,
  input wire logic otherCoreWaiting,
  output logic coreReqAccept,
  output logic coreReqReject,
  // External queue
  input wire logic [CNT_W-1:0] externalRejects,
  // Counter values
  output logic [NUM_PROG-1:0][CTR_W-1:0] progCount,
  output logic [NUM_FIX-1:0][CTR_W-1:0] fixCount
);
  typedef struct packed {
    logic missPend;
  } cpes_top_s;
  cpes_top_s state_q;
  cpes_top_s state_d;

  logic [EV_NUM-1:0][INC_W-1:0] incVec;
  logic [NUM_PROG-1:0][INC_W-1:0] progInc;
  logic [NUM_FIX-1:0][INC_W-1:0] fixInc;
  logic [NUM_PROG-1:0] progSupported;
  logic missStart;
  logic running;

  function automatic logic [INC_W-1:0] widen(input logic [CNT_W-1:0] v);
    return INC_W'(v);
  endfunction

  function automatic logic [INC_W-1:0] bitInc(input logic b);
    return INC_W'(b);
  endfunction

  // Maps a code and mask pair to an event slot; anything else is unsupported
  function automatic cpes_evt_e evtDecode(input logic [7:0] code, input logic [7:0] um);
    cpes_evt_e ev;
    ev = EV_NONE;
    unique case (code)
      EVC_CYCLES:
      begin
        if (um == UM_00)
          ev = EV_CORE_CYC;
        else if (um == UM_01)
          ev = EV_REF_CYC;
      end
      EVC_IFETCH:
      begin
        if (um == UM_01)
          ev = EV_IC_HIT;
        else if (um == UM_02)
          ev = EV_IC_MISS;
        else if (um == UM_03)
          ev = EV_IC_ALL;
      end
      EVC_NIP:
      begin
        if (um == UM_04)
          ev = EV_NIP_STALL;
      end
      EVC_OFFCORE:
      begin
        if (um == UM_01)
          ev = EV_OFC0;
        else if (um == UM_02)
          ev = EV_OFC1;
      end
      EVC_INST:
      begin
        if (um == UM_00)
          ev = EV_INST;
      end
      EVC_UOPS:
      begin
        if (um == UM_01)
          ev = EV_UOP_MS;
        else if (um == UM_10)
          ev = EV_UOP_ALL;
      end
      EVC_L2Q_REJ:
      begin
        if (um == UM_00)
          ev = EV_L2Q_REJ;
      end
      EVC_XQ_REJ:
      begin
        if (um == UM_00)
          ev = EV_XQ_REJ;
      end
      default:
        ev = EV_NONE;
    endcase
    return ev;
  endfunction

  cpes_queue_admit u_queue_admit (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .reqValid(coreReqValid),
    .reqDirtyEvict(coreReqDirtyEvict),
    .reqAddr(coreReqAddr),
    .pendValid(pendValid),
    .pendAddr(pendAddr),
    .queueFull(queueFull),
    .queueNearFull(queueNearFull),
    .otherWaiting(otherCoreWaiting),
    .reqAccept(coreReqAccept),
    .reqReject(coreReqReject)
  );

  // A miss is counted on its first outstanding cycle only
  always_comb
  begin
    state_d = state_q;
    state_d.missPend = fetchMissPend;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      state_q <= '0;
    else
      state_q <= state_d;
  end

  assign missStart = fetchMissPend && !state_q.missPend;
  assign running = !coreHalted;

  always_comb
  begin
    incVec = '0;
    incVec[EV_CORE_CYC] = bitInc(running);
    // Reference ticks arrive at maximum-frequency rate, so core clock changes do not matter
    incVec[EV_REF_CYC] = running ? widen(refTicks) : '0;
    incVec[EV_IC_HIT] = widen(fetchHit);
    incVec[EV_IC_MISS] = widen(fetchUncache) + bitInc(missStart);
    incVec[EV_IC_ALL] = widen(fetchHit) + incVec[EV_IC_MISS];
    incVec[EV_NIP_STALL] = bitInc(nipStallMiss);
    incVec[EV_OFC0] = bitInc(offcoreValid && |(offcoreType & offcoreFilterZero));
    incVec[EV_OFC1] = bitInc(offcoreValid && |(offcoreType & offcoreFilterOne));
    // Retirement reports the last micro-op only; no interrupt state gates it
    incVec[EV_INST] = widen(retiredInstr);
    incVec[EV_UOP_MS] = widen(retiredMsUops);
    incVec[EV_UOP_ALL] = widen(retiredUops);
    incVec[EV_L2Q_REJ] = bitInc(coreReqReject);
    incVec[EV_XQ_REJ] = widen(externalRejects);
  end

  // Fixed counters reuse the programmable slots, so the two cannot drift apart
  always_comb
  begin
    fixInc = '0;
    fixInc[FIX_INST] = fixEnable[FIX_INST] ? incVec[EV_INST] : '0;
    fixInc[FIX_CORE] = fixEnable[FIX_CORE] ? incVec[EV_CORE_CYC] : '0;
    fixInc[FIX_REF] = fixEnable[FIX_REF] ? incVec[EV_REF_CYC] : '0;
  end

  for (genvar p = 0; p < NUM_PROG; p++)
  begin : g_prog
    cpes_evt_e sel;
    assign sel = evtDecode(progEvtCode[p], progUmask[p]);
    assign progSupported[p] = (sel != EV_NONE);
    assign progInc[p] = (progEnable[p] && progSupported[p]) ? incVec[sel] : '0;
    cpes_counter u_prog_ctr (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .clear(ctrClear),
      .incAmt(progInc[p]),
      .count(progCount[p])
    );
  end

  for (genvar f = 0; f < NUM_FIX; f++)
  begin : g_fix
    cpes_counter u_fix_ctr (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .clear(ctrClear),
      .incAmt(fixInc[f]),
      .count(fixCount[f])
    );
  end

  // Counter checks work from the raw event inputs, so a decode slip cannot hide behind itself; miss and off-core filter checks read incVec
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  core_cycle_a: assert property (
    progEnable[0] && progEvtCode[0] == EVC_CYCLES && progUmask[0] == UM_00 && !ctrClear
    |=> progCount[0] == $past(progCount[0]) + CTR_W'(!$past(coreHalted)))
    else $error("unhalted core cycle count wrong");

  fixed_core_a: assert property (
    fixEnable[FIX_CORE] && !ctrClear
    |=> fixCount[FIX_CORE] == $past(fixCount[FIX_CORE]) + CTR_W'(!$past(coreHalted)))
    else $error("fixed core cycle counter wrong");

  ref_cycle_a: assert property (
    progEnable[1] && progEvtCode[1] == EVC_CYCLES && progUmask[1] == UM_01 && !ctrClear
    |=> progCount[1] == $past(progCount[1])
    + ($past(coreHalted) ? '0 : CTR_W'($past(refTicks))))
    else $error("reference cycles miscounted");

  fixed_ref_a: assert property (
    fixEnable[FIX_REF] && !coreHalted && !ctrClear
    |=> fixCount[FIX_REF] == $past(fixCount[FIX_REF]) + CTR_W'($past(refTicks)))
    else $error("fixed reference counter wrong");

  fetch_hit_a: assert property (
    progEnable[0] && progEvtCode[0] == EVC_IFETCH && progUmask[0] == UM_01 && !ctrClear
    |=> progCount[0] == $past(progCount[0]) + CTR_W'($past(fetchHit)))
    else $error("cache-served fetches miscounted");

  miss_once_a: assert property (
    fetchMissPend [*2] ##0 fetchUncache == '0 |-> incVec[EV_IC_MISS] == '0)
    else $error("outstanding miss counted more than once");

  miss_first_a: assert property (
    !fetchMissPend ##1 fetchMissPend |-> incVec[EV_IC_MISS] == widen(fetchUncache) + 1'b1)
    else $error("new miss not counted");

  fetch_all_a: assert property (
    progEnable[0] && progEvtCode[0] == EVC_IFETCH && progUmask[0] == UM_03 && !ctrClear
    |=> progCount[0] == $past(progCount[0]) + CTR_W'($past(fetchHit))
    + CTR_W'($past(fetchUncache))
    + CTR_W'($past(fetchMissPend) && !$past(fetchMissPend, 2)))
    else $error("all-fetch count differs from hits plus misses");

  nip_stall_a: assert property (
    progEnable[1] && progEvtCode[1] == EVC_NIP && progUmask[1] == UM_04
    && nipStallMiss && !ctrClear |=> progCount[1] == $past(progCount[1]) + 1'b1)
    else $error("fetch pointer stall cycle not counted");

  offcore_filt_a: assert property (
    offcoreValid && (offcoreType & offcoreFilterZero) == '0 |-> incVec[EV_OFC0] == '0)
    else $error("off-core response outside filter counted");

  offcore_one_a: assert property (
    offcoreValid && (offcoreType & offcoreFilterOne) == '0 |-> incVec[EV_OFC1] == '0)
    else $error("off-core response outside second filter counted");

  offcore_count_a: assert property (
    progEnable[0] && progEvtCode[0] == EVC_OFFCORE && progUmask[0] == UM_01 && !ctrClear
    |=> progCount[0] == $past(progCount[0])
    + CTR_W'($past(offcoreValid) && ($past(offcoreType) & $past(offcoreFilterZero)) != '0))
    else $error("filtered off-core responses miscounted");

  inst_ret_a: assert property (
    progEnable[0] && progEvtCode[0] == EVC_INST && progUmask[0] == UM_00 && !ctrClear
    |=> progCount[0] == $past(progCount[0]) + CTR_W'($past(retiredInstr)))
    else $error("retired instructions miscounted");

  fixed_inst_a: assert property (
    fixEnable[FIX_INST] && !ctrClear
    |=> fixCount[FIX_INST] == $past(fixCount[FIX_INST]) + CTR_W'($past(retiredInstr)))
    else $error("fixed instruction counter wrong");

  uops_ms_a: assert property (
    progEnable[1] && progEvtCode[1] == EVC_UOPS && progUmask[1] == UM_01 && !ctrClear
    |=> progCount[1] == $past(progCount[1]) + CTR_W'($past(retiredMsUops)))
    else $error("microcode micro-ops miscounted");

  uops_all_a: assert property (
    progEnable[1] && progEvtCode[1] == EVC_UOPS && progUmask[1] == UM_10 && !ctrClear
    |=> progCount[1] == $past(progCount[1]) + CTR_W'($past(retiredUops)))
    else $error("retired micro-ops miscounted");

  l2q_reject_a: assert property (
    progEnable[0] && progEvtCode[0] == EVC_L2Q_REJ && progUmask[0] == UM_00
    && coreReqReject && !ctrClear |=> progCount[0] == $past(progCount[0]) + 1'b1)
    else $error("queue reject not counted");

  xq_reject_a: assert property (
    progEnable[1] && progEvtCode[1] == EVC_XQ_REJ && progUmask[1] == UM_00 && !ctrClear
    |=> progCount[1] == $past(progCount[1]) + CTR_W'($past(externalRejects)))
    else $error("external queue rejects miscounted");

  unsupported_a: assert property (
    !progSupported[0] && !ctrClear |=> progCount[0] == $past(progCount[0]))
    else $error("unsupported selection changed counter");

  prog_disabled_a: assert property (
    !progEnable[1] && !ctrClear |=> progCount[1] == $past(progCount[1]))
    else $error("disabled counter changed");

  fixed_off_a: assert property (
    !fixEnable[FIX_REF] && !ctrClear |=> fixCount[FIX_REF] == $past(fixCount[FIX_REF]))
    else $error("disabled fixed counter changed");
endmodule
`default_nettype wire

/* dv/cpes_far_model.sv */
`default_nettype none
module cpes_far_model
  import cpes_pkg::*;
(
  // Pipeline
  output logic coreHalted,
  output logic [CNT_W-1:0] refTicks,
  output logic [CNT_W-1:0] retiredInstr,
  output logic [CNT_W-1:0] retiredUops,
  output logic [CNT_W-1:0] retiredMsUops,
  // Fetch
  output logic [CNT_W-1:0] fetchHit,
  output logic [CNT_W-1:0] fetchUncache,
  output logic fetchMissPend,
  output logic nipStallMiss,
  // Off-core responses and their filters
  output logic offcoreValid,
  output logic [FILT_W-1:0] offcoreType,
  output logic [FILT_W-1:0] offcoreFilterZero,
  output logic [FILT_W-1:0] offcoreFilterOne,
  // Shared and external queues
  output logic [PEND_N-1:0] pendValid,
  output logic [PEND_N-1:0][ADDR_W-1:0] pendAddr,
  output logic queueFull,
  output logic queueNearFull,
  output logic otherCoreWaiting,
  output logic [CNT_W-1:0] externalRejects
);
  timeunit 1ns;
  timeprecision 1ps;

  task automatic pipe(input logic h, input logic [CNT_W-1:0] r, i, u, m);
    coreHalted = h;
    refTicks = r;
    retiredInstr = i;
    retiredUops = u;
    retiredMsUops = m;
  endtask

  task automatic fetch(input logic [CNT_W-1:0] hit, unc, input logic miss, stall);
    fetchHit = hit;
    fetchUncache = unc;
    fetchMissPend = miss;
    nipStallMiss = stall;
  endtask

  task automatic offc(input logic v, input logic [FILT_W-1:0] t);
    offcoreValid = v;
    offcoreType = t;
  endtask

  task automatic queue(input logic f, n, o, input logic [PEND_N-1:0] pv,
                       input logic [CNT_W-1:0] ext);
    queueFull = f;
    queueNearFull = n;
    otherCoreWaiting = o;
    pendValid = pv;
    externalRejects = ext;
  endtask

  initial
  begin
    // One filter per off-core event, disjoint so a leak shows
    offcoreFilterZero = 16'h000f;
    offcoreFilterOne = 16'h00f0;
    for (int k = 0; k < PEND_N; k++)
      pendAddr[k] = 32'h00000100 + 32'(k);
    pipe(1'b1, '0, '0, '0, '0);
    fetch('0, '0, 1'b0, 1'b0);
    offc(1'b0, '0);
    queue(1'b0, 1'b0, 1'b0, '0, '0);
  end
endmodule
`default_nettype wire

/* dv/tb_core_perf_event_select.sv */
`default_nettype none
module tb_core_perf_event_select
  import cpes_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;

  logic core_clk = 1'b0;
  logic rst_n, ctrClear;
  logic [NUM_PROG-1:0][7:0] progEvtCode, progUmask;
  logic [NUM_PROG-1:0] progEnable;
  logic [NUM_FIX-1:0] fixEnable;
  logic [FILT_W-1:0] offcoreFilterZero, offcoreFilterOne, offcoreType;
  logic coreHalted, fetchMissPend, nipStallMiss, offcoreValid;
  logic [CNT_W-1:0] refTicks, retiredInstr, retiredUops, retiredMsUops;
  logic [CNT_W-1:0] fetchHit, fetchUncache, externalRejects;
  logic coreReqValid, coreReqDirtyEvict, coreReqAccept, coreReqReject;
  logic [ADDR_W-1:0] coreReqAddr;
  logic [PEND_N-1:0] pendValid;
  logic [PEND_N-1:0][ADDR_W-1:0] pendAddr;
  logic queueFull, queueNearFull, otherCoreWaiting;
  logic [NUM_PROG-1:0][CTR_W-1:0] progCount;
  logic [NUM_FIX-1:0][CTR_W-1:0] fixCount;
  int num_errors = 0;
  int comparisons = 0;

  cpes_far_model cpes_far_model_inst (
    .coreHalted(coreHalted),
    .refTicks(refTicks),
    .retiredInstr(retiredInstr),
    .retiredUops(retiredUops),
    .retiredMsUops(retiredMsUops),
    .fetchHit(fetchHit),
    .fetchUncache(fetchUncache),
    .fetchMissPend(fetchMissPend),
    .nipStallMiss(nipStallMiss),
    .offcoreValid(offcoreValid),
    .offcoreType(offcoreType),
    .offcoreFilterZero(offcoreFilterZero),
    .offcoreFilterOne(offcoreFilterOne),
    .pendValid(pendValid),
    .pendAddr(pendAddr),
    .queueFull(queueFull),
    .queueNearFull(queueNearFull),
    .otherCoreWaiting(otherCoreWaiting),
    .externalRejects(externalRejects)
  );
  cpes_top cpes_top_inst (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .progEvtCode(progEvtCode),
    .progUmask(progUmask),
    .progEnable(progEnable),
    .fixEnable(fixEnable),
    .ctrClear(ctrClear),
    .offcoreFilterZero(offcoreFilterZero),
    .offcoreFilterOne(offcoreFilterOne),
    .coreHalted(coreHalted),
    .refTicks(refTicks),
    .retiredInstr(retiredInstr),
    .retiredUops(retiredUops),
    .retiredMsUops(retiredMsUops),
    .fetchHit(fetchHit),
    .fetchUncache(fetchUncache),
    .fetchMissPend(fetchMissPend),
    .nipStallMiss(nipStallMiss),
    .offcoreValid(offcoreValid),
    .offcoreType(offcoreType),
    .coreReqValid(coreReqValid),
    .coreReqDirtyEvict(coreReqDirtyEvict),
    .coreReqAddr(coreReqAddr),
    .pendValid(pendValid),
    .pendAddr(pendAddr),
    .queueFull(queueFull),
    .queueNearFull(queueNearFull),
    .otherCoreWaiting(otherCoreWaiting),
    .coreReqAccept(coreReqAccept),
    .coreReqReject(coreReqReject),
    .externalRejects(externalRejects),
    .progCount(progCount),
    .fixCount(fixCount)
  );

  always #12.5 core_clk = ~core_clk;

  task automatic close_out();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic chk(input logic [CTR_W-1:0] got, exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  // Selects both programmable events and clears all counters for one edge
  task automatic setup(input logic [7:0] c0, m0, c1, m1);
    progEvtCode[0] = c0;
    progUmask[0] = m0;
    progEvtCode[1] = c1;
    progUmask[1] = m1;
    ctrClear = 1'b1;
    cyc(1);
    ctrClear = 1'b0;
  endtask

  task automatic t_cycles();
    setup(EVC_CYCLES, UM_00, EVC_CYCLES, UM_01);
    cpes_far_model_inst.pipe(1'b0, 3'h3, '0, '0, '0);
    cyc(5);
    cpes_far_model_inst.pipe(1'b1, 3'h3, '0, '0, '0);
    cyc(2);
    chk(progCount[0], 48'h5, "core cycles");
    chk(fixCount[FIX_CORE], 48'h5, "fixed core");
    chk(progCount[1], 48'hf, "ref cycles");
    chk(fixCount[FIX_REF], 48'hf, "fixed ref");
  endtask

  // Miss held for three cycles must count once; hits add two a cycle
  task automatic t_fetch(input logic [7:0] m0, c1, m1, input logic [CTR_W-1:0] e0, e1);
    setup(EVC_IFETCH, m0, c1, m1);
    cpes_far_model_inst.fetch(3'h2, 3'h1, 1'b1, 1'b1);
    cyc(1);
    cpes_far_model_inst.fetch(3'h2, 3'h0, 1'b1, 1'b1);
    cyc(2);
    cpes_far_model_inst.fetch('0, '0, 1'b0, 1'b0);
    cyc(1);
    chk(progCount[0], e0, "fetch a");
    chk(progCount[1], e1, "fetch b");
  endtask

  task automatic t_ret(input logic [7:0] c0, m0, c1, m1, input logic [CTR_W-1:0] e0, e1);
    setup(c0, m0, c1, m1);
    cpes_far_model_inst.pipe(1'b0, '0, 3'h3, 3'h7, 3'h2);
    cyc(2);
    cpes_far_model_inst.pipe(1'b0, '0, 3'h1, 3'h4, 3'h0);
    cyc(1);
    cpes_far_model_inst.pipe(1'b1, '0, '0, '0, '0);
    cyc(1);
    chk(progCount[0], e0, "retire a");
    chk(progCount[1], e1, "retire b");
    chk(fixCount[FIX_INST], 48'h7, "fixed instr");
  endtask

  task automatic t_offcore();
    setup(EVC_OFFCORE, UM_01, EVC_OFFCORE, UM_02);
    cpes_far_model_inst.offc(1'b1, 16'h0003);
    cyc(2);
    cpes_far_model_inst.offc(1'b1, 16'h0010);
    cyc(1);
    cpes_far_model_inst.offc(1'b1, 16'h0100);
    cyc(1);
    cpes_far_model_inst.offc(1'b0, 16'h00ff);
    cyc(2);
    chk(progCount[0], 48'h2, "offcore zero");
    chk(progCount[1], 48'h1, "offcore one");
  endtask

  // Admission is combinational, so it is judged 1 ns after the drive
  task automatic req(input logic d, input logic [ADDR_W-1:0] a, input logic acc);
    coreReqValid = 1'b1;
    coreReqDirtyEvict = d;
    coreReqAddr = a;
    #1;
    comparisons++;
    if (coreReqAccept !== acc || coreReqReject !== !acc)
    begin
      num_errors++;
      $display("MISMATCH %0t admit addr %h exp accept %b", $time, a, acc);
    end
    cyc(1);
  endtask

  task automatic t_queue();
    setup(EVC_L2Q_REJ, UM_00, EVC_XQ_REJ, UM_00);
    cpes_far_model_inst.queue(1'b1, 1'b0, 1'b0, '0, 3'h5);
    req(1'b0, 32'h00000200, 1'b0);
    cpes_far_model_inst.queue(1'b0, 1'b1, 1'b0, '0, 3'h2);
    req(1'b0, 32'h00000200, 1'b0);
    cpes_far_model_inst.queue(1'b0, 1'b0, 1'b0, 8'h08, '0);
    req(1'b1, 32'h00000103, 1'b0);
    req(1'b0, 32'h00000103, 1'b1);
    req(1'b1, 32'h00000105, 1'b1);
    cpes_far_model_inst.queue(1'b0, 1'b0, 1'b1, '0, '0);
    repeat (4) req(1'b0, 32'h00000200, 1'b1);
    req(1'b0, 32'h00000200, 1'b0);
    req(1'b0, 32'h00000200, 1'b1);
    coreReqValid = 1'b0;
    cpes_far_model_inst.queue(1'b0, 1'b0, 1'b0, '0, '0);
    cyc(1);
    chk(progCount[0], 48'h4, "queue rejects");
    chk(progCount[1], 48'h7, "external rejects");
  endtask

  // Bad mask on one counter, supported event but disabled on the other; fixed counters off
  task automatic t_unsup();
    progEnable = 2'b01;
    fixEnable = 3'b000;
    setup(EVC_CYCLES, 8'h07, EVC_CYCLES, UM_00);
    cpes_far_model_inst.pipe(1'b0, 3'h3, 3'h1, 3'h1, 3'h1);
    cyc(3);
    cpes_far_model_inst.pipe(1'b1, '0, '0, '0, '0);
    cyc(1);
    chk(progCount[0], '0, "unsupported");
    chk(progCount[1], '0, "disabled");
    chk(fixCount[FIX_REF], '0, "fixed ref disabled");
    chk(fixCount[FIX_CORE], '0, "fixed core disabled");
    progEnable = 2'b11;
    fixEnable = 3'b111;
  endtask

  initial
  begin
    repeat (2000) @(posedge core_clk);
    num_errors++;
    $display("MISMATCH %0t watchdog expired", $time);
    close_out();
  end

  initial
  begin
    rst_n = 1'b0;
    ctrClear = 1'b0;
    progEvtCode = '0;
    progUmask = '0;
    progEnable = 2'b11;
    fixEnable = 3'b111;
    coreReqValid = 1'b0;
    coreReqDirtyEvict = 1'b0;
    coreReqAddr = '0;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1'b1;
    cyc(1);
    chk(fixCount[FIX_INST], '0, "reset value");
    t_cycles();
    t_fetch(UM_01, EVC_IFETCH, UM_02, 48'h6, 48'h2);
    t_fetch(UM_03, EVC_NIP, UM_04, 48'h8, 48'h3);
    t_ret(EVC_INST, UM_00, EVC_UOPS, UM_01, 48'h7, 48'h4);
    t_ret(EVC_INST, UM_00, EVC_UOPS, UM_10, 48'h7, 48'h12);
    t_offcore();
    t_queue();
    t_unsup();
    close_out();
  end
endmodule
`default_nettype wire
